// *** logic/dsfm_pkg.sv ***
// constants and helpers for the drive status and fault monitor
// assumes one 100 MHz system clock and a synchronous active-low reset
package dsfm_pkg;
   // ===========================================================
   // register indices, word width, history depth
   localparam int REG_W = 16;
   localparam int HIST_N = 8;
   localparam logic [2:0] IDX_FREQ = 3'h0;
   localparam logic [2:0] IDX_CURR = 3'h1;
   localparam logic [2:0] IDX_VOLT = 3'h2;
   localparam logic [2:0] IDX_H12 = 3'h3;
   localparam logic [2:0] IDX_H34 = 3'h4;
   localparam logic [2:0] IDX_H56 = 3'h5;
   localparam logic [2:0] IDX_H78 = 3'h6;
   localparam logic [2:0] IDX_DIAG = 3'h7;
   localparam logic [15:0] MON_RST = 16'h0000;
   // ===========================================================
   // fault codes; upper nibble is the fault class
   localparam logic [7:0] FC_NONE = 8'h00;
   localparam logic [7:0] FC_RETRY_OVER = 8'hB2;
   localparam logic [7:0] FC_STORAGE = 8'hB3;
   localparam logic [7:0] FC_CPU = 8'hC0;
   localparam logic [7:0] FC_AUX_SUPPLY = 8'hC2;
   localparam logic [7:0] FC_INT1 = 8'hF1;
   localparam logic [7:0] FC_INT2 = 8'hF2;
   localparam logic [7:0] FC_INT6 = 8'hF6;
   localparam logic [7:0] FC_INT7 = 8'hF7;
   localparam logic [7:0] FC_INT13 = 8'hFD;
   // ===========================================================
   // self-diagnostic error numbers and limits
   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam logic [15:0] ERR_INSTR = 16'h000A;
   localparam logic [15:0] ERR_PARAM = 16'h000B;
   localparam logic [15:0] ERR_SCAN_OVERRUN = 16'h0016;
   localparam logic [15:0] ERR_MISSING_END = 16'h0018;
   localparam logic [15:0] MAIN_STEPS_MAX = 16'h1000;
   // ===========================================================
   // run indicator flash timing
   localparam int CLK_MHZ = 100;
   localparam int LED_HALF_MS = 250;
   localparam int LED_HALF_CYC = LED_HALF_MS * CLK_MHZ * 1000;

   function automatic logic dsfm_no_cancel(input logic [7:0] c);
      return c == FC_CPU || c == FC_AUX_SUPPLY || c == FC_STORAGE ||
         c == FC_INT1 || c == FC_INT2 || c == FC_INT6 ||
         c == FC_INT7 || c == FC_INT13;
   endfunction : dsfm_no_cancel
endpackage : dsfm_pkg

// *** logic/dsfm_if.sv ***
// signals between the monitor top and its history and diagnostic units
// assumes all three sit on the same clock and reset
`timescale 1ns/1ps
interface dsfm_if;
   logic scan_end;
   logic fault_evt;
   logic [7:0] fault_code;
   logic [3:0][15:0] hist_rd;
   logic err_instr;
   logic err_param;
   logic err_overrun;
   logic err_no_end;
   logic [15:0] err_num;
   logic err_present;
   logic led_run;
   modport top (output scan_end, fault_evt, fault_code, err_instr,
      err_param, err_overrun, err_no_end,
      input hist_rd, err_num, err_present, led_run);
   modport hist (input scan_end, fault_evt, fault_code,
      output hist_rd);
   modport diag (input err_instr, err_param, err_overrun, err_no_end,
      output err_num, err_present, led_run);
endinterface : dsfm_if

// *** logic/dsfm_hist.sv ***
// eight-deep fault code history, packed two codes per word
// assumes fault events are single-cycle pulses
`timescale 1ns/1ps
module dsfm_hist (
   input wire logic clk,
   input wire logic rst_n,
   dsfm_if.hist bus
);
   typedef struct packed {
      logic [dsfm_pkg::HIST_N-1:0][7:0] live;
      logic [3:0][15:0] snap;
   } dsfm_hist_s;
   dsfm_hist_s s_r;
   dsfm_hist_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (bus.fault_evt) begin
         s_nxt.live = {s_r.live[dsfm_pkg::HIST_N-2:0], bus.fault_code};
      end
      if (bus.scan_end) begin
         for (int i = 0; i < 4; i++) begin
            s_nxt.snap[i] = {s_r.live[2*i+1], s_r.live[2*i]};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.hist_rd = s_r.snap;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_evt_then_end;
      bus.fault_evt && !bus.scan_end ##1 bus.scan_end && !bus.fault_evt;
   endsequence
   property p_hist_newest;
      s_evt_then_end |=> bus.hist_rd[0][7:0] == $past(bus.fault_code, 2);
   endproperty
   a_hist_newest: assert property (p_hist_newest)
      else $error("newest fault code not in low byte of first word");
   property p_hist_hold;
      !bus.scan_end |=> $stable(bus.hist_rd);
   endproperty
   a_hist_hold: assert property (p_hist_hold)
      else $error("history words changed without scan end");
endmodule : dsfm_hist

// *** logic/dsfm_diag.sv ***
// self-diagnostic error number and run indicator
// assumes error strobes are single-cycle; only reset clears an error
`timescale 1ns/1ps
module dsfm_diag #(
   parameter int LED_HALF = dsfm_pkg::LED_HALF_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   dsfm_if.diag bus
);
   localparam int CW = $clog2(LED_HALF + 1);
   typedef struct packed {
      logic [15:0] num;
      logic present;
      logic [CW-1:0] cnt;
      logic led;
   } dsfm_diag_s;
   dsfm_diag_s s_r;
   dsfm_diag_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (!s_r.present) begin
         s_nxt.led = 1'b1;
         s_nxt.present = 1'b1;
         if (bus.err_instr) begin
            s_nxt.num = dsfm_pkg::ERR_INSTR;
         end else if (bus.err_param) begin
            s_nxt.num = dsfm_pkg::ERR_PARAM;
         end else if (bus.err_overrun) begin
            s_nxt.num = dsfm_pkg::ERR_SCAN_OVERRUN;
         end else if (bus.err_no_end) begin
            s_nxt.num = dsfm_pkg::ERR_MISSING_END;
         end else begin
            s_nxt.present = 1'b0;
         end
      end else if (s_r.cnt == CW'(LED_HALF - 1)) begin
         s_nxt.cnt = '0;
         s_nxt.led = !s_r.led;
      end else begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.err_num = s_r.num;
   assign bus.err_present = s_r.present;
   assign bus.led_run = s_r.led;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_overrun_num;
      bus.err_overrun && !bus.err_instr && !bus.err_param &&
         !bus.err_present |=> bus.err_num == 16'h0016 && bus.err_present;
   endproperty
   a_overrun_num: assert property (p_overrun_num)
      else $error("scan overrun did not store 22");
   property p_param_num;
      bus.err_param && !bus.err_instr && !bus.err_present
         |=> bus.err_num == 16'h000B;
   endproperty
   a_param_num: assert property (p_param_num)
      else $error("parameter error did not store 11");
   property p_led_flash;
      bus.err_present && $past(bus.err_present) && s_r.cnt == '0
         |-> bus.led_run != $past(bus.led_run);
   endproperty
   a_led_flash: assert property (p_led_flash)
      else $error("run indicator did not toggle");
endmodule : dsfm_diag

// *** logic/dsfm_top.sv ***
// drive status and fault monitor: monitors, fault history, fault
// cancel and self-diagnostic error stop, read by the sequence engine
// assumes all inputs synchronous to CLK_SYS, events are 1-cycle pulses
`timescale 1ns/1ps

module dsfm_top #(
   parameter bit CURR_COARSE = 1'b0,
   parameter int LED_HALF = dsfm_pkg::LED_HALF_CYC
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic SCAN_END,
   input wire logic [15:0] FREQ_IN,
   input wire logic [15:0] CURR_IN,
   input wire logic [15:0] VOLT_IN,
   input wire logic [2:0] REG_SEL,
   input wire logic REG_WR,
   input wire logic FAULT_EVT,
   input wire logic [7:0] FAULT_CODE,
   input wire logic FAULT_CANCEL_INPUT,
   input wire logic RETRY_ACTIVE,
   input wire logic START_EXT,
   input wire logic PANEL_START_REQ,
   input wire logic COMM_START_REQ,
   input wire logic BAD_OPCODE,
   input wire logic OPERAND_BAD,
   input wire logic INSTR_BASIC,
   input wire logic EXEC_COND,
   input wire logic [15:0] MAIN_STEPS,
   input wire logic BAD_FUNC,
   input wire logic SCAN_OVERRUN,
   input wire logic END_MISSING,
   input wire logic [15:0] PROG_OUT_IN,
   output logic [15:0] REG_RDATA,
   output logic REG_WR_REJECT,
   output logic FAULT_ACTIVE,
   output logic [7:0] ACTIVE_CODE,
   output logic CANCEL_DONE,
   output logic PANEL_START,
   output logic COMM_START,
   output logic DRIVE_RUN,
   output logic HEAT_CLEAR,
   output logic ERROR_STOP,
   output logic RUN_LED,
   output logic [15:0] PROG_OUT
);
   // ===========================================================
   // types and state
   typedef enum logic [2:0] {
      ST_OK = 3'b001,
      ST_FAULT = 3'b010,
      ST_ESTOP = 3'b100
   } dsfm_st_e;

   typedef struct packed {
      dsfm_st_e st;
      logic [15:0] freq;
      logic [15:0] curr;
      logic [15:0] volt;
      logic [7:0] code;
      logic panel;
      logic comm;
      logic run;
      logic cancel;
      logic heat_clr;
      logic wr_rej;
      logic [15:0] rdata;
      logic [15:0] prog_out;
   } dsfm_top_s;

   localparam dsfm_top_s RST_VAL = '{
      st: ST_OK,
      freq: dsfm_pkg::MON_RST,
      curr: dsfm_pkg::MON_RST,
      volt: dsfm_pkg::MON_RST,
      code: dsfm_pkg::FC_NONE,
      panel: 1'b0,
      comm: 1'b0,
      run: 1'b0,
      cancel: 1'b0,
      heat_clr: 1'b1,
      wr_rej: 1'b0,
      rdata: 16'h0000,
      prog_out: 16'h0000
   };

   dsfm_top_s s_r;
   dsfm_top_s s_nxt;
   dsfm_if bus ();

   // ===========================================================
   // helpers
   function automatic logic [15:0] dsfm_div10(input logic [15:0] v);
      logic [31:0] p;
      p = 32'(v) * 32'h0000CCCD;
      // product fits 32 bits for any 16-bit input; quotient is exact
      return 16'(p >> 19);
   endfunction : dsfm_div10

   logic cancel_ok;
   logic [15:0] curr_scaled;

   assign curr_scaled = CURR_COARSE ? dsfm_div10(CURR_IN) : CURR_IN;

   assign cancel_ok = FAULT_CANCEL_INPUT &&
      (!RETRY_ACTIVE || s_r.code == dsfm_pkg::FC_RETRY_OVER) &&
      !dsfm_pkg::dsfm_no_cancel(s_r.code);

   // ===========================================================
   // submodule hookup
   assign bus.scan_end = SCAN_END;
   // zero code is not a fault
   assign bus.fault_evt = FAULT_EVT && FAULT_CODE != dsfm_pkg::FC_NONE;
   assign bus.fault_code = FAULT_CODE;
   assign bus.err_instr = BAD_OPCODE ||
      (OPERAND_BAD && (INSTR_BASIC || EXEC_COND));
   assign bus.err_param = MAIN_STEPS > dsfm_pkg::MAIN_STEPS_MAX ||
      BAD_FUNC;
   assign bus.err_overrun = SCAN_OVERRUN;
   assign bus.err_no_end = END_MISSING;

   dsfm_hist u_hist (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .bus(bus.hist)
   );

   dsfm_diag #(
      .LED_HALF(LED_HALF)
   ) u_diag (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .bus(bus.diag)
   );

   // ===========================================================
   // next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.cancel = 1'b0;
      // heat is only dropped by a device reset, never by cancel
      s_nxt.heat_clr = 1'b0;
      s_nxt.wr_rej = REG_WR;
      if (SCAN_END) begin
         s_nxt.freq = FREQ_IN;
         s_nxt.curr = curr_scaled;
         s_nxt.volt = VOLT_IN;
      end
      if (PANEL_START_REQ) begin
         s_nxt.panel = 1'b1;
      end
      if (COMM_START_REQ) begin
         s_nxt.comm = 1'b1;
      end
      case (s_r.st)
         ST_OK: begin
            if (bus.fault_evt) begin
               s_nxt.st = ST_FAULT;
               s_nxt.code = FAULT_CODE;
            end
         end
         ST_FAULT: begin
            if (bus.fault_evt) begin
               s_nxt.code = FAULT_CODE;
            end else if (cancel_ok) begin
               s_nxt.st = ST_OK;
               s_nxt.code = dsfm_pkg::FC_NONE;
               s_nxt.cancel = 1'b1;
               s_nxt.panel = 1'b0;
               s_nxt.comm = 1'b0;
            end
         end
         ST_ESTOP: begin
         end
         default: begin
            s_nxt.st = ST_OK;
         end
      endcase
      if (bus.err_present) begin
         s_nxt.st = ST_ESTOP;
      end
      s_nxt.run = s_nxt.st == ST_OK && !s_nxt.cancel &&
         (START_EXT || s_nxt.panel || s_nxt.comm);
      s_nxt.prog_out = s_nxt.st == ST_ESTOP ? 16'h0000 : PROG_OUT_IN;
      case (REG_SEL)
         dsfm_pkg::IDX_FREQ: s_nxt.rdata = s_r.freq;
         dsfm_pkg::IDX_CURR: s_nxt.rdata = s_r.curr;
         dsfm_pkg::IDX_VOLT: s_nxt.rdata = s_r.volt;
         dsfm_pkg::IDX_H12: s_nxt.rdata = bus.hist_rd[0];
         dsfm_pkg::IDX_H34: s_nxt.rdata = bus.hist_rd[1];
         dsfm_pkg::IDX_H56: s_nxt.rdata = bus.hist_rd[2];
         dsfm_pkg::IDX_H78: s_nxt.rdata = bus.hist_rd[3];
         dsfm_pkg::IDX_DIAG: s_nxt.rdata = bus.err_num;
         default: s_nxt.rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         s_r <= RST_VAL;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ===========================================================
   // outputs
   assign REG_RDATA = s_r.rdata;
   assign REG_WR_REJECT = s_r.wr_rej;
   assign FAULT_ACTIVE = s_r.st == ST_FAULT;
   assign ACTIVE_CODE = s_r.code;
   assign CANCEL_DONE = s_r.cancel;
   assign PANEL_START = s_r.panel;
   assign COMM_START = s_r.comm;
   assign DRIVE_RUN = s_r.run;
   assign HEAT_CLEAR = s_r.heat_clr;
   assign ERROR_STOP = s_r.st == ST_ESTOP;
   assign RUN_LED = bus.led_run;
   assign PROG_OUT = s_r.prog_out;

   // ===========================================================
   // checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   sequence s_cancel_try;
      FAULT_ACTIVE && FAULT_CANCEL_INPUT && !bus.fault_evt &&
         !bus.err_present;
   endsequence
   sequence s_cancel_take;
      !FAULT_ACTIVE && CANCEL_DONE && !PANEL_START && !COMM_START;
   endsequence

   property p_mon_hold;
      !SCAN_END |=> $stable(s_r.freq) && $stable(s_r.volt);
   endproperty
   a_mon_hold: assert property (p_mon_hold)
      else $error("monitor changed outside scan end");

   property p_mon_load;
      SCAN_END |=> s_r.freq == $past(FREQ_IN);
   endproperty
   a_mon_load: assert property (p_mon_load)
      else $error("frequency monitor not loaded at scan end");

   property p_cancel;
      s_cancel_try and (!RETRY_ACTIVE) and
         (!dsfm_pkg::dsfm_no_cancel(ACTIVE_CODE)) |=> s_cancel_take;
   endproperty
   a_cancel: assert property (p_cancel)
      else $error("cancel did not clear fault and starts");

   property p_retry_block;
      FAULT_ACTIVE && RETRY_ACTIVE &&
         ACTIVE_CODE != dsfm_pkg::FC_RETRY_OVER |=> !CANCEL_DONE;
   endproperty
   a_retry_block: assert property (p_retry_block)
      else $error("cancel taken during retry");

   property p_no_cancel;
      FAULT_ACTIVE && dsfm_pkg::dsfm_no_cancel(ACTIVE_CODE) &&
         !bus.err_present |=> FAULT_ACTIVE;
   endproperty
   a_no_cancel: assert property (p_no_cancel)
      else $error("protected fault class was cancelled");

   property p_stop_after;
      CANCEL_DONE |-> !DRIVE_RUN ##1 (!START_EXT || DRIVE_RUN ||
         ERROR_STOP || FAULT_ACTIVE || !$past(START_EXT));
   endproperty
   a_stop_after: assert property (p_stop_after)
      else $error("run state wrong around cancel");

   property p_estop_out;
      ERROR_STOP ##1 ERROR_STOP |-> PROG_OUT == 16'h0000;
   endproperty
   a_estop_out: assert property (p_estop_out)
      else $error("program outputs not cleared in error stop");

   property p_heat;
      $past(RST_N) |-> !HEAT_CLEAR;
   endproperty
   a_heat: assert property (p_heat)
      else $error("heat cleared outside reset");
endmodule : dsfm_top

// *** bench/dsfm_top_tb.sv ***
// self-checking bench for the drive status and fault monitor top
// assumes dsfm_pkg is compiled first; run indicator half period shortened
`timescale 1ns/1ps
module dsfm_top_tb;
   // short flash period keeps the toggle count exact and the run brief
   localparam int LH = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic scan = 1'b0;
   logic wr = 1'b0;
   logic fevt = 1'b0;
   logic cancel = 1'b0;
   logic retry = 1'b0;
   logic start = 1'b0;
   logic preq = 1'b0;
   logic creq = 1'b0;
   logic bop = 1'b0;
   logic obad = 1'b0;
   logic basic = 1'b0;
   logic econd = 1'b0;
   logic bfunc = 1'b0;
   logic ovr = 1'b0;
   logic nend = 1'b0;
   logic [2:0] sel = 3'h0;
   logic [7:0] fcode = 8'h00;
   logic [15:0] freq = 16'h0000;
   logic [15:0] curr = 16'h0000;
   logic [15:0] volt = 16'h0000;
   logic [15:0] steps = 16'h0000;
   logic [15:0] pin = 16'h0000;
   logic [15:0] rdata;
   logic [15:0] pout;
   logic [7:0] acode;
   logic wrej, fact, cdone, pst, cst, run, heat, estop, led;
   int n_fail = 0;
   int checks_done = 0;

   always #5 clk = ~clk;

   dsfm_top #(.CURR_COARSE(1'b0), .LED_HALF(LH)) dut_u (
      .CLK_SYS(clk), .RST_N(rst_n), .SCAN_END(scan), .FREQ_IN(freq),
      .CURR_IN(curr), .VOLT_IN(volt), .REG_SEL(sel), .REG_WR(wr),
      .FAULT_EVT(fevt), .FAULT_CODE(fcode), .FAULT_CANCEL_INPUT(cancel),
      .RETRY_ACTIVE(retry), .START_EXT(start), .PANEL_START_REQ(preq),
      .COMM_START_REQ(creq), .BAD_OPCODE(bop), .OPERAND_BAD(obad),
      .INSTR_BASIC(basic), .EXEC_COND(econd), .MAIN_STEPS(steps),
      .BAD_FUNC(bfunc), .SCAN_OVERRUN(ovr), .END_MISSING(nend),
      .PROG_OUT_IN(pin), .REG_RDATA(rdata), .REG_WR_REJECT(wrej),
      .FAULT_ACTIVE(fact), .ACTIVE_CODE(acode), .CANCEL_DONE(cdone),
      .PANEL_START(pst), .COMM_START(cst), .DRIVE_RUN(run),
      .HEAT_CLEAR(heat), .ERROR_STOP(estop), .RUN_LED(led),
      .PROG_OUT(pout));

   // ===========================================================
   // helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
      input string what);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic stop_test();
      if (n_fail == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   // inputs always move 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic rd(input logic [2:0] s, output logic [15:0] d);
      sel = s;
      step(1);
      d = rdata;
   endtask : rd

   task automatic do_reset(input int n);
      rst_n = 1'b0;
      step(n);
      chk(heat, 16'h1, "heat in reset");
      rst_n = 1'b1;
      step(1);
      chk(heat, 16'h0, "heat after reset");
      chk(estop, 16'h0, "error stop after reset");
   endtask : do_reset

   task automatic fault(input logic [7:0] c);
      fcode = c;
      fevt = 1'b1;
      step(1);
      fevt = 1'b0;
      fcode = 8'h00;
   endtask : fault

   task automatic pulse_scan();
      scan = 1'b1;
      step(1);
      scan = 1'b0;
   endtask : pulse_scan

   // ===========================================================
   // scenarios
   task automatic t_mon();
      logic [15:0] d;
      logic [15:0] e [3];
      e = '{16'h1770, 16'h00C8, 16'h03E8};
      freq = e[0];
      curr = e[1];
      volt = e[2];
      pulse_scan();
      freq = 16'h0001;
      curr = 16'h0002;
      volt = 16'h0003;
      wr = 1'b1;
      for (int i = 0; i < 3; i++) begin
         rd(3'(i), d);
         chk(d, e[i], "monitor held");
         chk(wrej, 16'h1, "write reject");
      end
      wr = 1'b0;
      pulse_scan();
      rd(dsfm_pkg::IDX_VOLT, d);
      chk(d, 16'h0003, "monitor refresh");
   endtask : t_mon

   task automatic t_hist();
      logic [15:0] d;
      logic [7:0] c [9];
      c = '{8'h10, 8'h11, 8'h12, 8'h20, 8'h21, 8'h22, 8'h30, 8'h31, 8'h40};
      fault(8'h00);
      chk(fact, 16'h0, "zero code");
      for (int i = 0; i < 9; i++) begin
         fault(c[i]);
      end
      rd(dsfm_pkg::IDX_H12, d);
      chk(d, 16'h0000, "history before scan");
      pulse_scan();
      for (int k = 0; k < 4; k++) begin
         rd(3'(int'(dsfm_pkg::IDX_H12) + k), d);
         chk(d, {c[7 - 2 * k], c[8 - 2 * k]}, "history word");
      end
      chk(acode, 16'h40, "active code");
      // event then scan on the next edge: newest lands in the low byte
      fault(8'h51);
      pulse_scan();
      rd(dsfm_pkg::IDX_H12, d);
      chk(d, {c[8], 8'h51}, "newest first");
   endtask : t_hist

   task automatic t_cancel();
      start = 1'b1;
      preq = 1'b1;
      creq = 1'b1;
      step(1);
      preq = 1'b0;
      creq = 1'b0;
      fault(8'h31);
      chk({pst, cst, run, fact}, 16'hD, "tripped");
      cancel = 1'b1;
      step(1);
      cancel = 1'b0;
      chk({cdone, fact, run}, 16'h4, "cancel taken");
      chk({pst, cst}, 16'h0, "starts cleared");
      chk(heat, 16'h0, "heat kept");
      step(1);
      chk({cdone, run}, 16'h1, "resume");
      start = 1'b0;
   endtask : t_cancel

   task automatic t_retry();
      retry = 1'b1;
      fault(8'h30);
      cancel = 1'b1;
      step(2);
      chk(fact, 16'h1, "cancel in retry");
      fault(dsfm_pkg::FC_RETRY_OVER);
      step(1);
      chk(fact, 16'h0, "cancel retry over");
      cancel = 1'b0;
      retry = 1'b0;
   endtask : t_retry

   task automatic t_lock();
      logic [7:0] c [8];
      c = '{8'hB3, 8'hC0, 8'hC2, 8'hF1, 8'hF2, 8'hF6, 8'hF7, 8'hFD};
      for (int i = 0; i < 8; i++) begin
         fault(c[i]);
         cancel = 1'b1;
         step(2);
         chk(fact, 16'h1, "locked class");
         cancel = 1'b0;
      end
   endtask : t_lock

   task automatic cause(input int k, input logic v);
      case (k)
         0: bop = v;
         1: begin
            obad = v;
            basic = v;
         end
         2: begin
            obad = v;
            econd = v;
         end
         3: steps = v ? 16'h1001 : 16'h0000;
         4: bfunc = v;
         5: ovr = v;
         6: nend = v;
         default: begin
            obad = v;
            steps = v ? 16'h1000 : 16'h0000;
         end
      endcase
   endtask : cause

   // case 7 is an unchecked operand and an in-range capacity
   task automatic t_diag(input int k, input logic [15:0] e);
      logic [15:0] d;
      logic prev;
      int tog;
      do_reset(2);
      pin = 16'hA5C3;
      step(2);
      chk(pout, 16'hA5C3, "outputs pass");
      cause(k, 1'b1);
      step(1);
      cause(k, 1'b0);
      rd(dsfm_pkg::IDX_DIAG, d);
      chk(d, e, "error number");
      chk(estop, {15'h0, k != 7}, "error stop");
      chk(pout, (k != 7) ? 16'h0000 : 16'hA5C3, "outputs");
      tog = 0;
      prev = led;
      for (int i = 0; i < 4 * LH; i++) begin
         step(1);
         tog += int'(led !== prev);
         prev = led;
      end
      chk(16'(tog), (k != 7) ? 16'h4 : 16'h0, "led flash");
      if (k != 7) begin
         nend = 1'b1;
         step(1);
         nend = 1'b0;
         rd(dsfm_pkg::IDX_DIAG, d);
         chk(d, e, "first error kept");
      end
   endtask : t_diag

   // ===========================================================
   // main sequence and hang guard
   initial begin
      logic [15:0] ex [8];
      ex = '{dsfm_pkg::ERR_INSTR, dsfm_pkg::ERR_INSTR, dsfm_pkg::ERR_INSTR,
         dsfm_pkg::ERR_PARAM, dsfm_pkg::ERR_PARAM,
         dsfm_pkg::ERR_SCAN_OVERRUN, dsfm_pkg::ERR_MISSING_END,
         dsfm_pkg::ERR_NONE};
      do_reset(8);
      t_mon();
      do_reset(2);
      t_hist();
      do_reset(2);
      t_cancel();
      do_reset(2);
      t_retry();
      do_reset(2);
      t_lock();
      for (int k = 0; k < 8; k++) begin
         t_diag(k, ex[k]);
      end
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("ERROR %0t run limit reached", $time);
      stop_test();
   end
endmodule : dsfm_top_tb
